// file: acs_sequencer.sv
// Purpose: conversion sequencer for a multi-channel 12-bit SAR converter
// Assumes: inputs synchronous to sys_clk; the analog result arrives on conv_result
// Notes: FIFO words are {channel, result}; conversion timings are typical figures, low times minimums
// Operation
// - mode 00 scans on conversion-register write when monitor on; default
// - monitor on: busy, scan, store, then drop
// - mode 01: one start pulse scans all
// - mode 11: one conversion per start pulse
// - temperature: reference 45us, sensor 5us, 30us
// - first temperature 80us, later 30us
// - external-reference voltage: 1.5us low, 3.5us
// - first internal-reference voltage needs 50us low
// - later internal-reference voltage: 1.5us, 5.6us
// - two clock-select bits choose mode, live
// - leaving mode 00 finishes series, then idle
// - leaving mode 01 idle unless sequence running
// - leaving mode 11 idle, busy low unless converting
// - continuous convert bit repeats the scan
`timescale 1ns/1ps
`include "acs_params.svh"
module acs_sequencer (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // configuration bits
  input wire logic clock_select_high,
  input wire logic clock_select_low,
  input wire logic conversion_monitor_enable,
  input wire logic continuous_convert_bit,
  input wire logic use_internal_ref,
  // conversion register write
  input wire logic conv_write,
  input wire logic [`ACS_CHAN_COUNT-1:0] conv_channels,
  input wire logic [`ACS_CHAN_COUNT-1:0] temp_channels,
  input wire logic fifo_clear,
  // trigger pin, active low
  input wire logic conversion_start_pin_n,
  // analog core
  input wire logic [`ACS_DATA_W-1:0] conv_result,
  output logic adc_power,
  output logic ref_power,
  output logic sensor_power,
  output logic sample,
  output logic [`ACS_CHAN_W-1:0] active_channel,
  // status
  output logic busy,
  output logic [1:0] mode,
  // result FIFO drain side
  output logic res_valid,
  input wire logic res_ready,
  output logic [`ACS_CHAN_W+`ACS_DATA_W-1:0] res_data,
  output logic [`ACS_FIFO_AW:0] res_level
);
  localparam int W = `ACS_CHAN_W + `ACS_DATA_W;
  localparam logic [15:0] CYC_START = 16'(`ACS_CYC_MIN(`ACS_T_START_MIN_NS));
  localparam logic [15:0] CYC_VLOW = 16'(`ACS_CYC_MIN(`ACS_T_VOLT_LOW_MIN_NS));
  localparam logic [15:0] CYC_VINT1 = 16'(`ACS_CYC_MIN(`ACS_T_VINT_FIRST_LOW_NS));
  localparam logic [15:0] CYC_REF = 16'(`ACS_CYC_TYP(`ACS_T_REF_UP_NS));
  localparam logic [15:0] CYC_SENS = 16'(`ACS_CYC_TYP(`ACS_T_SENSOR_UP_NS));
  localparam logic [15:0] CYC_TCONV = 16'(`ACS_CYC_TYP(`ACS_T_TEMP_CONV_NS));
  localparam logic [15:0] CYC_VEXT = 16'(`ACS_CYC_TYP(`ACS_T_VEXT_CONV_NS));
  localparam logic [15:0] CYC_VINT = 16'(`ACS_CYC_TYP(`ACS_T_VINT_CONV_NS));

  acs_pkg::acs_state_t state;
  acs_pkg::acs_state_t next_state;
  acs_pkg::acs_kind_t kind;
  logic [1:0] run_mode;
  logic [`ACS_CHAN_COUNT-1:0] pending;
  logic [`ACS_CHAN_COUNT-1:0] selected;
  logic [15:0] low_count;
  logic ref_warm;
  logic vint_warm;
  logic stop_req;
  logic tmr_load;
  logic [15:0] tmr_count;
  logic tmr_done;
  logic tmr_running;
  logic fifo_in_ready;
  logic fifo_in_valid;
  logic [W-1:0] fifo_in_data;
  logic trig_ok;
  logic [`ACS_CHAN_W-1:0] first_chan;
  logic [`ACS_CHAN_COUNT-1:0] pick_src;

  // lowest pending channel; used for pick and for clear
  function automatic logic [`ACS_CHAN_W-1:0] acs_first(
    input logic [`ACS_CHAN_COUNT-1:0] v);
    logic [`ACS_CHAN_W-1:0] idx;
    idx = '0;
    for (int i = `ACS_CHAN_COUNT - 1; i >= 0; i--)
      if (v[i])
        idx = `ACS_CHAN_W'(i);
    return idx;
  endfunction

  assign mode = {clock_select_high, clock_select_low};
  assign pick_src = (state == acs_pkg::ACS_IDLE) ? conv_channels :
                    (state == acs_pkg::ACS_FINISH && pending == '0) ? selected : pending;
  assign first_chan = acs_first(pick_src);

  // minimum low time depends on what the next conversion will be
  always_comb
  begin
    trig_ok = 1'b0;
    if (conversion_start_pin_n)
    begin
      if (temp_channels[first_chan] || run_mode == `ACS_MODE_PULSE)
        trig_ok = (low_count >= CYC_START);
      else if (use_internal_ref && !vint_warm)
        trig_ok = (low_count >= CYC_VINT1);
      else
        trig_ok = (low_count >= CYC_VLOW);
    end
  end

  // count the low time of the start pin; trigger is taken at release
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      low_count <= '0;
    else if (clk_en)
    begin
      if (!conversion_start_pin_n)
      begin
        if (low_count != 16'hFFFF)
          low_count <= low_count + 16'h0001;
      end
      else
        low_count <= '0;
    end
  end

  // a mode change while running is remembered, finishing the work first
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      stop_req <= 1'b0;
    else if (clk_en)
    begin
      if (state == acs_pkg::ACS_IDLE)
        stop_req <= 1'b0;
      else if (mode != run_mode)
        stop_req <= 1'b1;
    end
  end

  always_comb
  begin
    next_state = state;
    unique case (state)
      acs_pkg::ACS_IDLE:
        if (conv_write && conv_channels != '0)
        begin
          if (mode == `ACS_MODE_SCAN && conversion_monitor_enable)
            next_state = acs_pkg::ACS_POWER;
          else if (mode == `ACS_MODE_PULSE || mode == `ACS_MODE_EACH)
            next_state = acs_pkg::ACS_WAIT_TRIG;
          // reserved mode: stay idle
        end
      acs_pkg::ACS_WAIT_TRIG:
        if (mode != run_mode)
          next_state = acs_pkg::ACS_IDLE;
        else if (trig_ok)
          next_state = acs_pkg::ACS_POWER;
      acs_pkg::ACS_POWER:
        if (tmr_done)
          next_state = acs_pkg::ACS_CONVERT;
      acs_pkg::ACS_CONVERT:
        if (tmr_done)
          next_state = acs_pkg::ACS_STORE;
      acs_pkg::ACS_STORE:
        if (fifo_in_ready)
          next_state = acs_pkg::ACS_FINISH;
      acs_pkg::ACS_FINISH:
        if (pending != '0 && run_mode == `ACS_MODE_EACH && !stop_req)
          next_state = acs_pkg::ACS_WAIT_TRIG;
        else if (pending != '0)
          next_state = acs_pkg::ACS_POWER;
        else if (continuous_convert_bit && !stop_req && selected != '0)
          next_state = acs_pkg::ACS_POWER;
        else
          next_state = acs_pkg::ACS_IDLE;
    endcase
    if (state == acs_pkg::ACS_FINISH && stop_req && run_mode == `ACS_MODE_EACH)
      next_state = acs_pkg::ACS_IDLE;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      state <= acs_pkg::ACS_IDLE;
    else if (clk_en)
      state <= next_state;
  end

  // channel bookkeeping and the mode a run was started under
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pending <= '0;
      selected <= '0;
      run_mode <= `ACS_MODE_RESET;
      active_channel <= '0;
    end
    else if (clk_en)
    begin
      if (conv_write)
        selected <= conv_channels;
      if (state == acs_pkg::ACS_IDLE && next_state != acs_pkg::ACS_IDLE)
      begin
        pending <= conv_channels;
        run_mode <= mode;
      end
      else if (state == acs_pkg::ACS_FINISH && pending == '0)
        pending <= selected;
      else if (state == acs_pkg::ACS_STORE && fifo_in_ready)
        pending[first_chan] <= 1'b0;
      if (next_state == acs_pkg::ACS_POWER)
        active_channel <= first_chan;
    end
  end

  // warm-up history: reference and sensor stay up between conversions
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ref_warm <= 1'b0;
      vint_warm <= 1'b0;
      kind <= acs_pkg::ACS_KIND_TEMP;
    end
    else if (clk_en)
    begin
      if (next_state == acs_pkg::ACS_POWER)
      begin
        if (temp_channels[first_chan])
          kind <= acs_pkg::ACS_KIND_TEMP;
        else if (use_internal_ref)
          kind <= acs_pkg::ACS_KIND_VINT;
        else
          kind <= acs_pkg::ACS_KIND_VEXT;
      end
      if (state == acs_pkg::ACS_CONVERT && tmr_done)
      begin
        if (kind == acs_pkg::ACS_KIND_TEMP)
          ref_warm <= 1'b1;
        if (kind == acs_pkg::ACS_KIND_VINT)
          vint_warm <= 1'b1;
      end
    end
  end

  // power-up time: cold temperature adds reference and sensor start
  always_comb
  begin
    tmr_load = 1'b0;
    tmr_count = 16'h0001;
    if (state == acs_pkg::ACS_POWER && !tmr_running && !tmr_done)
    begin
      tmr_load = 1'b1;
      if (kind == acs_pkg::ACS_KIND_TEMP && !ref_warm)
        tmr_count = CYC_REF + CYC_SENS;
    end
    else if (state == acs_pkg::ACS_CONVERT && !tmr_running && !tmr_done)
    begin
      tmr_load = 1'b1;
      unique case (kind)
        acs_pkg::ACS_KIND_TEMP: tmr_count = CYC_TCONV;
        acs_pkg::ACS_KIND_VEXT: tmr_count = CYC_VEXT;
        acs_pkg::ACS_KIND_VINT: tmr_count = vint_warm ? CYC_VINT : CYC_VEXT;
        default: tmr_count = CYC_VEXT;
      endcase
    end
  end

  acs_timer u_timer (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .load(tmr_load),
    .count(tmr_count),
    .abort(1'b0),
    .running(tmr_running),
    .done(tmr_done)
  );

  // result capture; the sequencer stalls in STORE while the FIFO is full
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      fifo_in_data <= '0;
    else if (clk_en && state == acs_pkg::ACS_CONVERT && tmr_done)
      fifo_in_data <= {active_channel, conv_result};
  end
  assign fifo_in_valid = (state == acs_pkg::ACS_STORE);

  acs_fifo #(
    .WIDTH(W),
    .DEPTH(`ACS_FIFO_DEPTH),
    .AW(`ACS_FIFO_AW)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .flush(fifo_clear),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data),
    .level(res_level)
  );

  // busy falls only after the last store; low while awaiting a trigger
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      busy <= 1'b0;
    else if (clk_en)
      busy <= (next_state == acs_pkg::ACS_POWER || next_state == acs_pkg::ACS_CONVERT ||
               next_state == acs_pkg::ACS_STORE || next_state == acs_pkg::ACS_FINISH) &&
              (run_mode == `ACS_MODE_EACH || state != acs_pkg::ACS_IDLE ||
               conversion_monitor_enable || mode != `ACS_MODE_SCAN);
  end

  // analog power controls from flip-flops
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      adc_power <= 1'b0;
      ref_power <= 1'b0;
      sensor_power <= 1'b0;
      sample <= 1'b0;
    end
    else if (clk_en)
    begin
      adc_power <= (next_state != acs_pkg::ACS_IDLE && next_state != acs_pkg::ACS_WAIT_TRIG);
      sample <= (next_state == acs_pkg::ACS_POWER);
      if (next_state == acs_pkg::ACS_POWER && temp_channels[first_chan])
      begin
        ref_power <= 1'b1;
        sensor_power <= 1'b1;
      end
      else if (next_state == acs_pkg::ACS_POWER && use_internal_ref)
        ref_power <= 1'b1;
    end
  end
endmodule // acs_sequencer

// file: acs_params.svh
// Purpose: constants for the conversion sequencer
// Assumes: sys_clk at 250 MHz (4 ns period)
// Notes: times are in ns; cycle counts derive from them
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH
`define ACS_CLK_PERIOD_NS 4
`define ACS_CHAN_COUNT 11
`define ACS_CHAN_W 4
`define ACS_DATA_W 12
`define ACS_FIFO_DEPTH 16
`define ACS_FIFO_AW 4
`define ACS_MODE_SCAN 2'h0
`define ACS_MODE_PULSE 2'h1
`define ACS_MODE_RSVD 2'h2
`define ACS_MODE_EACH 2'h3
`define ACS_MODE_RESET 2'h0
`define ACS_T_START_MIN_NS 20
`define ACS_T_VOLT_LOW_MIN_NS 1500
`define ACS_T_REF_UP_NS 45000
`define ACS_T_SENSOR_UP_NS 5000
`define ACS_T_TEMP_CONV_NS 30000
`define ACS_T_VEXT_CONV_NS 3500
`define ACS_T_VINT_FIRST_LOW_NS 50000
`define ACS_T_VINT_CONV_NS 5600
`define ACS_CYC_MIN(ns) (((ns) + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)
`define ACS_CYC_TYP(ns) ((ns) / `ACS_CLK_PERIOD_NS)
`endif

// file: acs_pkg.sv
// Purpose: types for the conversion sequencer
// Assumes: one-hot state coding
// Notes: none
package acs_pkg;
  typedef enum logic [5:0] {
    ACS_IDLE = 6'h01,
    ACS_WAIT_TRIG = 6'h02,
    ACS_POWER = 6'h04,
    ACS_CONVERT = 6'h08,
    ACS_STORE = 6'h10,
    ACS_FINISH = 6'h20
  } acs_state_t;
  typedef enum logic [1:0] {
    ACS_KIND_TEMP = 2'h0,
    ACS_KIND_VEXT = 2'h1,
    ACS_KIND_VINT = 2'h2
  } acs_kind_t;
endpackage

// file: acs_fifo.sv
// Purpose: result FIFO with valid/ready on both sides
// Assumes: synchronous flush
// Notes: full and empty are exact; no bypass path
`timescale 1ns/1ps
`include "acs_params.svh"
module acs_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [AW:0] level
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push;
  logic pop;
  assign in_ready = (level != (AW+1)'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge sys_clk)
  begin
    if (clk_en && push)
      mem[wr_ptr] <= in_data;
  end
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end
    else if (clk_en)
    begin
      if (flush)
      begin
        wr_ptr <= '0;
        rd_ptr <= '0;
        level <= '0;
      end
      else
      begin
        if (push)
          wr_ptr <= wr_ptr + AW'(1);
        if (pop)
          rd_ptr <= rd_ptr + AW'(1);
        if (push && !pop)
          level <= level + (AW+1)'(1);
        else if (pop && !push)
          level <= level - (AW+1)'(1);
      end
    end
  end
endmodule // acs_fifo

// file: acs_timer.sv
// Purpose: down-counter for power-up and conversion intervals
// Assumes: load takes priority over counting
// Notes: done is a one-cycle pulse on reaching zero
`timescale 1ns/1ps
module acs_timer (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // control
  input wire logic load,
  input wire logic [15:0] count,
  input wire logic abort,
  // status
  output logic running,
  output logic done
);
  logic [15:0] remain;
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      remain <= '0;
      running <= 1'b0;
      done <= 1'b0;
    end
    else if (clk_en)
    begin
      done <= 1'b0;
      if (abort)
        running <= 1'b0;
      else if (load)
      begin
        remain <= count;
        running <= 1'b1;
      end
      else if (running)
      begin
        if (remain <= 16'h0001)
        begin
          running <= 1'b0;
          done <= 1'b1;
        end
        else
          remain <= remain - 16'h0001;
      end
    end
  end
endmodule // acs_timer

// file: acs_seq_monitor.sv
// Purpose: port-level checks of the conversion sequencer
// Assumes: clk_en held high
// Notes: bound to acs_sequencer below
`timescale 1ns/1ps
`include "acs_params.svh"
module acs_seq_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // configuration and requests
  input wire logic conversion_monitor_enable,
  input wire logic continuous_convert_bit,
  input wire logic conv_write,
  input wire logic [`ACS_CHAN_COUNT-1:0] conv_channels,
  input wire logic fifo_clear,
  input wire logic conversion_start_pin_n,
  // status and results
  input wire logic adc_power,
  input wire logic [`ACS_CHAN_W-1:0] active_channel,
  input wire logic busy,
  input wire logic [1:0] mode,
  input wire logic res_valid,
  input wire logic res_ready,
  input wire logic [`ACS_CHAN_W+`ACS_DATA_W-1:0] res_data,
  input wire logic [`ACS_FIFO_AW:0] res_level
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  int busy_len;
  // counts the current busy stretch so its length can be judged when it ends
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      busy_len <= 0;
    else
      busy_len <= busy ? busy_len + 1 : 0;
  end
  chk_scan_start: assert property (mode == 2'h0 && conversion_monitor_enable && conv_write
    && !busy && !continuous_convert_bit && conv_channels != '0 |=> busy)
    else $error("scan write did not raise busy");
  chk_busy_power: assert property ($rose(busy) |-> adc_power)
    else $error("busy rose without converter power");
  chk_drop_stored: assert property ($fell(busy) |-> $past(res_valid))
    else $error("busy fell with no stored result");
  chk_conv_time: assert property ($fell(busy) |-> busy_len >= 875)
    else $error("busy stretch shorter than a conversion");
  chk_rsvd_idle: assert property (mode == 2'h2 && $stable(mode) && !busy |=> !busy)
    else $error("busy rose in reserved mode");
  chk_leave_idle: assert property ($changed(mode) && !busy && !conv_write
    && !$past(conv_write) && $stable(conversion_start_pin_n) |=> !busy && !adc_power)
    else $error("mode change while waiting did not idle");
  chk_fifo_hold: assert property (res_valid && !res_ready && !fifo_clear
    |=> res_valid && $stable(res_data))
    else $error("unread result changed or vanished");
  chk_valid_level: assert property (res_valid == (res_level != '0))
    else $error("result valid disagrees with fill level");
  chk_chan_range: assert property (busy |-> active_channel < 4'hB)
    else $error("active channel out of range");
endmodule // acs_seq_monitor

bind acs_sequencer acs_seq_monitor u_mon (
  .sys_clk(sys_clk), .rst_b(rst_b), .conv_write(conv_write), .conv_channels(conv_channels),
  .conversion_monitor_enable(conversion_monitor_enable), .fifo_clear(fifo_clear),
  .continuous_convert_bit(continuous_convert_bit), .adc_power(adc_power),
  .conversion_start_pin_n(conversion_start_pin_n), .active_channel(active_channel),
  .busy(busy), .mode(mode), .res_valid(res_valid), .res_ready(res_ready),
  .res_data(res_data), .res_level(res_level));

// file: acs_host_model.sv
// Purpose: host side model driving the start pin and draining results
// Assumes: pulse length given in clock cycles
// Notes: ready stalls at random about one cycle in four
`timescale 1ns/1ps
module acs_host_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // commands from the bench
  input wire logic pulse_go,
  input wire logic [15:0] pulse_len,
  input wire logic drain_en,
  // toward the sequencer
  output logic conversion_start_pin_n,
  output logic res_ready
);
  logic [15:0] low_left;
  // pin idles high; each request gives one low of exactly pulse_len cycles
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      low_left <= 16'h0;
      conversion_start_pin_n <= 1'b1;
    end
    else if (pulse_go)
    begin
      low_left <= pulse_len;
      conversion_start_pin_n <= 1'b0;
    end
    else if (low_left > 16'h1)
      low_left <= low_left - 16'h1;
    else
    begin
      low_left <= 16'h0;
      conversion_start_pin_n <= 1'b1;
    end
  end
  // random stalls make the fifo hold words across cycles
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      res_ready <= 1'b0;
    else
      res_ready <= drain_en && ($urandom_range(0, 3) != 0);
  end
endmodule // acs_host_model

// file: acs_sequencer_tb.sv
// Purpose: self-checking bench for the conversion sequencer
// Assumes: external reference outside the internal-reference test; clk_en high except one 50-cycle freeze
// Notes: expected words come from a queue model
`timescale 1ns/1ps
`include "acs_params.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
$display("BAD %s exp %0h got %0h", nm, e, g); end end
module acs_sequencer_tb;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cks_h = 1'b0;
  logic cks_l = 1'b0;
  logic mon = 1'b1;
  logic cont = 1'b0;
  logic wr = 1'b0;
  logic fclr = 1'b0;
  logic go = 1'b0;
  logic drain = 1'b1;
  logic [15:0] plen = 16'h0;
  logic [10:0] chans = '0;
  logic [10:0] temps = '0;
  logic [11:0] res = '0;
  logic [15:0] word;
  logic [15:0] cont_word = '0;
  logic [15:0] expq[$];
  logic pin_n, ready, adc_power, busy, res_valid, ref_pwr, sens_pwr, smp;
  logic ce = 1'b1;
  logic iref = 1'b0;
  logic [1:0] mode;
  logic [15:0] res_data;
  logic [4:0] res_level;
  int checked = 0;
  int miscompares = 0;
  int k;
  int seed_dummy;
  initial
  begin
    forever #2 sys_clk = ~sys_clk;
  end
  acs_sequencer uut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(ce),
    .clock_select_high(cks_h), .clock_select_low(cks_l), .conversion_monitor_enable(mon),
    .continuous_convert_bit(cont), .use_internal_ref(iref), .conv_write(wr),
    .conv_channels(chans), .temp_channels(temps), .fifo_clear(fclr),
    .conversion_start_pin_n(pin_n), .conv_result(res), .adc_power(adc_power),
    .ref_power(ref_pwr), .sensor_power(sens_pwr), .sample(smp), .active_channel(),
    .busy(busy), .mode(mode), .res_valid(res_valid), .res_ready(ready), .res_data(res_data),
    .res_level(res_level));
  acs_host_model host (.sys_clk(sys_clk), .rst_b(rst_b), .pulse_go(go), .pulse_len(plen),
    .drain_en(drain), .conversion_start_pin_n(pin_n), .res_ready(ready));
  // every popped word is matched against the model queue, or against cont_word once the queue is empty
  always @(posedge sys_clk)
  begin
    if (rst_b && ce === 1'b1 && res_valid === 1'b1 && ready === 1'b1)
    begin
      word = (expq.size() != 0) ? expq.pop_front() : cont_word;
      `CHK("fifo word", word, res_data)
    end
  end
  task automatic conclude();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic write(input logic [10:0] c);
    chans = c;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
  endtask
  task automatic expect_all(input logic [10:0] c);
    for (int i = 0; i < 11; i++)
      if (c[i])
        expq.push_back({i[3:0], res});
  endtask
  task automatic wait_busy(input logic v, input int lim);
    k = 0;
    while (busy !== v && k < lim)
    begin
      cyc(1);
      k++;
    end
    if (busy !== v)
    begin
      miscompares++;
      $display("BAD busy exp %0h got %0h", v, busy);
      conclude();
    end
  endtask
  task automatic pulse(input logic [15:0] len, input int lim);
    plen = len;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    wait_busy(1'b1, int'(len) + 20);
    wait_busy(1'b0, lim);
  endtask
  task automatic scan(input logic [10:0] c, input int lim);
    expect_all(c);
    write(c);
    wait_busy(1'b1, 3);
    `CHK("adc power", 1'b1, adc_power)
    `CHK("sample", 1'b1, smp)
    wait_busy(1'b0, lim);
  endtask
  task automatic drained();
    int n;
    n = 0;
    while ((expq.size() != 0 || res_level !== 5'h0) && n < 20000)
    begin
      cyc(1);
      n++;
    end
    `CHK("fifo level", 5'h0, res_level)
    `CHK("words left", 0, expq.size())
    if (n >= 20000)
      conclude();
  endtask
  initial
  begin
    seed_dummy = $urandom(32'hAFD32258);
    cyc(10);
    rst_b = 1'b1;
    `CHK("busy", 1'b0, busy)
    `CHK("mode", 2'h0, mode)
    res = 12'($urandom());
    scan(11'($urandom_range(1, 2047)), 15000);
    drained();
    `CHK("ref off", 2'h0, {ref_pwr, sens_pwr})
    $display("test scan on write done");
    for (int m = 1; m < 4; m += 2)
    begin
      {cks_h, cks_l} = 2'(m);
      res = 12'($urandom());
      expect_all(11'h402);
      write(11'h402);
      pulse(m == 1 ? 16'd8 : 16'd400, 3000);
      if (m == 3)
        pulse(16'd400, 3000);
      drained();
    end
    $display("test pulse modes done");
    // mode 10 and leaving a waiting mode must both ignore the following pulse
    for (int m = 1; m < 4; m++)
    begin
      {cks_h, cks_l} = 2'(m);
      write(11'h001);
      cyc(5);
      {cks_h, cks_l} = (m == 2) ? 2'h2 : 2'h0;
      plen = 16'd400;
      go = 1'b1;
      cyc(1);
      go = 1'b0;
      k = 0;
      repeat (1000)
      begin
        cyc(1);
        if (busy !== 1'b0 || adc_power !== 1'b0)
          k++;
      end
      `CHK("busy cycles", 0, k)
    end
    {cks_h, cks_l} = 2'h0;
    `CHK("level", 5'h0, res_level)
    $display("test idle exits done");
    expect_all(11'h006);
    write(11'h006);
    wait_busy(1'b1, 3);
    cyc(10);
    ce = 1'b0;
    cyc(50);
    `CHK("frozen busy", 1'b1, busy && adc_power)
    ce = 1'b1;
    {cks_h, cks_l} = 2'h3;
    wait_busy(1'b0, 5000);
    `CHK("series kept", 1'b1, k > 1700)
    drained();
    $display("test mode change mid scan done");
    temps = 11'h020;
    for (int t = 0; t < 2; t++)
    begin
      expect_all(11'h020);
      write(11'h020);
      pulse(16'd8, 25000);
      `CHK("temp time", 1'b1, t == 0 ? k > 19000 : (k > 7400 && k < 8000))
    end
    drained();
    `CHK("temp power", 2'h3, {ref_pwr, sens_pwr})
    $display("test temperature done");
    temps = '0;
    iref = 1'b1;
    for (int t = 0; t < 2; t++)
    begin
      expect_all(11'h004);
      write(11'h004);
      pulse(t == 0 ? 16'd12600 : 16'd400, 3000);
      k -= (t == 0) ? 875 : 1400;
      `CHK("vint time", 1'b1, k > 0 && k < 30)
    end
    iref = 1'b0;
    drained();
    $display("test internal reference done");
    {cks_h, cks_l} = 2'h0;
    temps = '0;
    drain = 1'b0;
    cont = 1'b1;
    cont_word = {4'h0, res};
    write(11'h001);
    k = 0;
    while (res_level !== 5'h10 && k < 20000)
    begin
      cyc(1);
      k++;
    end
    cyc(2000);
    `CHK("full level", 5'h10, res_level)
    if (k >= 20000)
      conclude();
    `CHK("stalled busy", 1'b1, busy)
    write(11'h000);
    cont = 1'b0;
    drain = 1'b1;
    wait_busy(1'b0, 20000);
    {cks_h, cks_l} = 2'h1;
    cyc(2);
    {cks_h, cks_l} = 2'h0;
    fclr = 1'b1;
    cyc(1);
    fclr = 1'b0;
    cyc(2);
    `CHK("cleared level", 5'h0, res_level)
    scan(11'h001, 3000);
    drained();
    $display("test continuous done");
    conclude();
  end
endmodule // acs_sequencer_tb
